/* File: logic/tof_measurement_sequencer.sv */
// measurement sequencer of the time-of-flight sensor with its register file
//
// How it works
// - power-on reset returns every register to default and the sequencer to idle
// - chip enable pin is active low and powers blocks and the register port
// - with chip enable low, disable bit 0 stops the chip; zero re-enables
// - software disable register resets to zero, chip enabled
// - enable changes never alter register contents
// - sample trigger pin starts a measurement; host pulses it per start
// - triggers arriving during a running measurement are ignored
// - soft-start command starts a measurement just like the trigger pin
// - soft-reset command restores register defaults except the brownout flag
// - soft-clear command stops conversions, clears accumulator, halts continuous running
// - with interrupts enabled, each completed sensing cycle raises an interrupt
// - interrupt pin is active low open drain, released when no enabled interrupt is pending
// - reading interrupt status services the interrupt and clears the register
// - single shot stops after a measurement; continuous restarts at the sampling period
// - mode register bit 0: zero continuous, one single shot
// - single shot makes one measurement per trigger lasting the integration time
// - continuous sampling is the mode after reset
// - continuous mode flags new data and interrupts after every measurement
// - interval count and range registers allow intervals of several seconds
// - pulsed emitter current set by 4-bit range and 8-bit fine registers
// - threshold dac current flows only during integration
// - interval is 450 us times one plus count shifted by range
`timescale 1ns/100ps
`include "tof_defines.svh"
module tof_measurement_sequencer #(
    parameter int TICK_CYCLES = `TOF_SAMPLE_UNIT_NS / `TOF_CLK_PERIOD_NS,
    parameter logic [6:0] DEV_ADDR = `TOF_I2C_ADDR
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_chip_enable_low,
    input wire logic i_sample_start,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_drive_n,
    output logic o_irq_out,
    output logic o_irq_drive_n,
    output logic o_bias_on,
    output logic o_measuring,
    output logic o_sample_done,
    output logic o_emitter_pulse_en,
    output logic [3:0] o_emitter_range,
    output logic [7:0] o_emitter_fine,
    output logic [7:0] o_threshold_current
);
    localparam int INTEG_CYCLES = (`TOF_INTEG_UNIT_NS + `TOF_CLK_PERIOD_NS - 1) / `TOF_CLK_PERIOD_NS;

    logic cen_m, cen_s, ss_m, ss_s, ss_q;
    logic wr_stb, rd_stb, sda_drive;
    logic [7:0] bus_addr, wr_data, rd_data;
    logic chip_disable, brownout, mode_single, irq_enable, irq_status;
    logic [7:0] integ_length, interval_count, interval_range;
    logic [7:0] emit_range, emit_fine, emit_thresh, sample_count;
    tof_pkg::seq_state_t state;
    logic [15:0] integ_left;
    logic [23:0] tick_div, period_left;
    logic chip_active, ss_rise, cmd_wr, soft_start, soft_reset, soft_clear;
    logic seq_stop, trigger, meas_done, start_meas, tick, status_read;
    logic [15:0] integ_load;

    function automatic logic [23:0] interval_ticks(input logic [7:0] count, input logic [3:0] shift);
        interval_ticks = 24'h000001 + (24'(count) << shift);
    endfunction

    tof_i2c_target #(
        .DEV_ADDR(DEV_ADDR)
    ) u_port (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_enable(!cen_s),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .i_rdata(rd_data),
        .o_sda_drive(sda_drive),
        .o_wr_stb(wr_stb),
        .o_rd_stb(rd_stb),
        .o_addr(bus_addr),
        .o_wdata(wr_data)
    );

    // pin synchronisers; the pin idles with the chip not enabled
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cen_m <= 1'b1;
            cen_s <= 1'b1;
            ss_m <= 1'b0;
            ss_s <= 1'b0;
            ss_q <= 1'b0;
        end else begin
            cen_m <= i_chip_enable_low;
            cen_s <= cen_m;
            ss_m <= i_sample_start;
            ss_s <= ss_m;
            ss_q <= ss_s;
        end
    end

    assign chip_active = !cen_s && !chip_disable;
    assign ss_rise = ss_s && !ss_q;
    assign cmd_wr = wr_stb && bus_addr == `TOF_REG_COMMAND;
    assign soft_start = cmd_wr && wr_data == `TOF_CMD_SOFT_START;
    assign soft_reset = cmd_wr && wr_data == `TOF_CMD_SOFT_RESET;
    assign soft_clear = cmd_wr && wr_data == `TOF_CMD_SOFT_CLEAR;
    assign seq_stop = soft_reset || soft_clear || !chip_active;
    assign trigger = ss_rise || soft_start;
    assign tick = tick_div == 24'(TICK_CYCLES - 1);
    assign meas_done = state == tof_pkg::SEQ_INTEGRATE && integ_left == 16'h0001;
    assign integ_load = 16'((int'(integ_length) + 1) * INTEG_CYCLES);
    assign status_read = rd_stb && bus_addr == `TOF_REG_IRQ_STATUS;
    // a new trigger only counts from idle; a running measurement swallows it
    assign start_meas = !seq_stop && ((state == tof_pkg::SEQ_IDLE && trigger) ||
        (state == tof_pkg::SEQ_WAIT_PERIOD && period_left == 24'h000000));

    // software registers; enable changes leave them untouched
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            chip_disable <= 1'b0;
            mode_single <= 1'b0;
            irq_enable <= 1'b0;
            integ_length <= `TOF_RST_INTEG_LENGTH;
            interval_count <= `TOF_RST_ZERO;
            interval_range <= `TOF_RST_ZERO;
            emit_range <= `TOF_RST_ZERO;
            emit_fine <= `TOF_RST_ZERO;
            emit_thresh <= `TOF_RST_ZERO;
        end else if (soft_reset) begin
            chip_disable <= 1'b0;
            mode_single <= 1'b0;
            irq_enable <= 1'b0;
            integ_length <= `TOF_RST_INTEG_LENGTH;
            interval_count <= `TOF_RST_ZERO;
            interval_range <= `TOF_RST_ZERO;
            emit_range <= `TOF_RST_ZERO;
            emit_fine <= `TOF_RST_ZERO;
            emit_thresh <= `TOF_RST_ZERO;
        end else if (wr_stb) begin
            unique case (bus_addr)
                `TOF_REG_CHIP_DISABLE: chip_disable <= wr_data[0];
                `TOF_REG_MODE: mode_single <= wr_data[0];
                `TOF_REG_IRQ_CFG: irq_enable <= wr_data[0];
                `TOF_REG_INTEG_LENGTH: integ_length <= wr_data;
                `TOF_REG_INTERVAL_COUNT: interval_count <= wr_data;
                `TOF_REG_INTERVAL_RANGE: interval_range <= wr_data;
                `TOF_REG_EMIT_RANGE: emit_range <= wr_data;
                `TOF_REG_EMIT_FINE: emit_fine <= wr_data;
                `TOF_REG_EMIT_THRESH: emit_thresh <= wr_data;
                default: begin
                end
            endcase
        end
    end

    // brownout flag survives soft reset; software clears it by writing zero
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            brownout <= 1'b1;
        end else if (wr_stb && bus_addr == `TOF_REG_SUPPLY_FLAGS) begin
            brownout <= brownout && wr_data[0];
        end
    end

    // sequencer state
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state <= tof_pkg::SEQ_IDLE;
        end else if (seq_stop) begin
            state <= tof_pkg::SEQ_IDLE;
        end else begin
            unique case (state)
                tof_pkg::SEQ_IDLE: begin
                    if (trigger) begin
                        state <= tof_pkg::SEQ_INTEGRATE;
                    end
                end
                tof_pkg::SEQ_INTEGRATE: begin
                    if (meas_done && mode_single == `TOF_MODE_SINGLE) begin
                        state <= tof_pkg::SEQ_IDLE;
                    end else if (meas_done) begin
                        state <= tof_pkg::SEQ_WAIT_PERIOD;
                    end
                end
                tof_pkg::SEQ_WAIT_PERIOD: begin
                    if (start_meas) begin
                        state <= tof_pkg::SEQ_INTEGRATE;
                    end
                end
                default: begin
                    state <= tof_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // integration and sampling-period timers, restarted with each measurement
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            integ_left <= 16'h0000;
            tick_div <= 24'h000000;
            period_left <= 24'h000000;
        end else if (start_meas) begin
            integ_left <= integ_load;
            tick_div <= 24'h000000;
            period_left <= interval_ticks(interval_count, interval_range[3:0]);
        end else begin
            if (state == tof_pkg::SEQ_INTEGRATE && integ_left != 16'h0000) begin
                integ_left <= integ_left - 16'h0001;
            end
            tick_div <= tick ? 24'h000000 : tick_div + 24'h000001;
            if (tick && period_left != 24'h000000) begin
                period_left <= period_left - 24'h000001;
            end
        end
    end

    // completion flag: a completion in the reading cycle wins over the clear
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            irq_status <= 1'b0;
        end else if (soft_reset) begin
            irq_status <= 1'b0;
        end else if (meas_done) begin
            irq_status <= 1'b1;
        end else if (status_read) begin
            irq_status <= 1'b0;
        end
    end

    // completed-sample accumulator
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            sample_count <= 8'h00;
        end else if (soft_reset || soft_clear) begin
            sample_count <= 8'h00;
        end else if (meas_done) begin
            sample_count <= sample_count + 8'h01;
        end
    end

    // read data is captured when the port fetches a byte
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rd_data <= 8'h00;
        end else if (rd_stb) begin
            unique case (bus_addr)
                `TOF_REG_CHIP_DISABLE: rd_data <= {7'h00, chip_disable};
                `TOF_REG_SUPPLY_FLAGS: rd_data <= {7'h00, brownout};
                `TOF_REG_MODE: rd_data <= {7'h00, mode_single};
                `TOF_REG_IRQ_CFG: rd_data <= {7'h00, irq_enable};
                `TOF_REG_INTEG_LENGTH: rd_data <= integ_length;
                `TOF_REG_INTERVAL_COUNT: rd_data <= interval_count;
                `TOF_REG_INTERVAL_RANGE: rd_data <= interval_range;
                `TOF_REG_IRQ_STATUS: rd_data <= {7'h00, irq_status};
                `TOF_REG_SAMPLE_COUNT: rd_data <= sample_count;
                `TOF_REG_EMIT_RANGE: rd_data <= emit_range;
                `TOF_REG_EMIT_FINE: rd_data <= emit_fine;
                `TOF_REG_EMIT_THRESH: rd_data <= emit_thresh;
                default: rd_data <= 8'h00;
            endcase
        end
    end

    // pin and analog-control outputs
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_sda_out <= 1'b0;
            o_sda_drive_n <= 1'b1;
            o_irq_out <= 1'b0;
            o_irq_drive_n <= 1'b1;
            o_bias_on <= 1'b0;
            o_measuring <= 1'b0;
            o_sample_done <= 1'b0;
            o_emitter_pulse_en <= 1'b0;
            o_emitter_range <= 4'h0;
            o_emitter_fine <= 8'h00;
            o_threshold_current <= 8'h00;
        end else begin
            o_sda_out <= 1'b0;
            o_sda_drive_n <= !sda_drive;
            o_irq_out <= 1'b0;
            o_irq_drive_n <= !(irq_enable && irq_status);
            o_bias_on <= chip_active;
            o_measuring <= state != tof_pkg::SEQ_IDLE;
            o_sample_done <= meas_done;
            o_emitter_pulse_en <= state == tof_pkg::SEQ_INTEGRATE;
            o_emitter_range <= emit_range[3:0];
            o_emitter_fine <= emit_fine;
            o_threshold_current <= state == tof_pkg::SEQ_INTEGRATE ? emit_thresh : 8'h00;
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    sequence s_cmd(logic [7:0] code);
        wr_stb && bus_addr == `TOF_REG_COMMAND && wr_data == code;
    endsequence
    sequence s_idle_ready;
        state == tof_pkg::SEQ_IDLE && chip_active;
    endsequence

    property p_pin_start;
        s_idle_ready ##0 (ss_rise && !cmd_wr) |=> state == tof_pkg::SEQ_INTEGRATE && integ_left == $past(integ_load);
    endproperty
    a_pin_start: assert property (p_pin_start) else $error("trigger pin did not start");
    property p_soft_start;
        s_idle_ready ##0 s_cmd(`TOF_CMD_SOFT_START) |=> state == tof_pkg::SEQ_INTEGRATE;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft start did not start");
    property p_busy_ignore;
        state == tof_pkg::SEQ_INTEGRATE && trigger && !seq_stop && !meas_done
            |=> state == tof_pkg::SEQ_INTEGRATE && integ_left == $past(integ_left) - 16'h0001;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("trigger disturbed a measurement");
    property p_disabled_idle;
        !chip_active |=> state == tof_pkg::SEQ_IDLE && !o_bias_on;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("disabled chip kept sensing");
    property p_soft_reset;
        s_cmd(`TOF_CMD_SOFT_RESET) |=> !mode_single && !chip_disable && state == tof_pkg::SEQ_IDLE
            && brownout == $past(brownout) && emit_fine == `TOF_RST_ZERO;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset result wrong");
    property p_soft_clear;
        s_cmd(`TOF_CMD_SOFT_CLEAR) |=> state == tof_pkg::SEQ_IDLE && sample_count == 8'h00;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft clear did not stop");
    property p_unknown_cmd;
        cmd_wr && !soft_start && !soft_reset && !soft_clear
            |=> mode_single == $past(mode_single) && emit_range == $past(emit_range);
    endproperty
    a_unknown_cmd: assert property (p_unknown_cmd) else $error("unknown command had an effect");
    property p_irq_raise;
        meas_done && irq_enable && !soft_reset |=> irq_status ##1 !o_irq_drive_n;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("completion raised no interrupt");
    property p_read_clear;
        status_read && !meas_done && !soft_reset |=> !irq_status ##1 o_irq_drive_n;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear");
    property p_single_stop;
        meas_done && mode_single && !seq_stop |=> state == tof_pkg::SEQ_IDLE;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single shot kept running");
    property p_cont_next;
        meas_done && !mode_single && !seq_stop |=> state != tof_pkg::SEQ_IDLE;
    endproperty
    a_cont_next: assert property (p_cont_next) else $error("continuous mode stopped");
    property p_thresh_gate;
        state != tof_pkg::SEQ_INTEGRATE |=> o_threshold_current == 8'h00;
    endproperty
    a_thresh_gate: assert property (p_thresh_gate) else $error("threshold current outside integration");
endmodule

/* File: logic/tof_defines.svh */
// register offsets, command codes, reset values and timing figures of the measurement sequencer
`ifndef TOF_DEFINES_SVH
`define TOF_DEFINES_SVH
`define TOF_REG_CHIP_DISABLE 8'h01
`define TOF_REG_SUPPLY_FLAGS 8'h02
`define TOF_REG_INTEG_LENGTH 8'h10
`define TOF_REG_INTERVAL_COUNT 8'h11
`define TOF_REG_INTERVAL_RANGE 8'h12
`define TOF_REG_MODE 8'h13
`define TOF_REG_IRQ_CFG 8'h14
`define TOF_REG_IRQ_STATUS 8'h60
`define TOF_REG_SAMPLE_COUNT 8'h61
`define TOF_REG_EMIT_RANGE 8'h90
`define TOF_REG_EMIT_FINE 8'h91
`define TOF_REG_EMIT_THRESH 8'h93
`define TOF_REG_COMMAND 8'hb0
`define TOF_CMD_SOFT_START 8'h49
`define TOF_CMD_SOFT_RESET 8'hd7
`define TOF_CMD_SOFT_CLEAR 8'hd1
`define TOF_RST_ZERO 8'h00
`define TOF_RST_INTEG_LENGTH 8'h0f
`define TOF_MODE_SINGLE 1'b1
`define TOF_CLK_PERIOD_NS 40
`define TOF_SAMPLE_UNIT_NS 450000
`define TOF_INTEG_UNIT_NS 1000
`define TOF_I2C_ADDR 7'h57
`endif

/* File: logic/tof_pkg.sv */
// types shared by the sequencer and its register port
package tof_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_INTEGRATE = 2'b01,
        SEQ_WAIT_PERIOD = 2'b11
    } seq_state_t;
    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_PTR = 3'b011,
        I2C_WDATA = 3'b010,
        I2C_RDATA = 3'b110
    } i2c_phase_t;
endpackage

/* File: logic/tof_i2c_target.sv */
// i2c register port: oversampled target with auto-incrementing register pointer
`timescale 1ns/100ps
`include "tof_defines.svh"
module tof_i2c_target #(
    parameter logic [6:0] DEV_ADDR = `TOF_I2C_ADDR
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [7:0] i_rdata,
    output logic o_sda_drive,
    output logic o_wr_stb,
    output logic o_rd_stb,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
    logic in_ack, host_ack;
    logic [3:0] bit_cnt;
    logic [7:0] shifter;
    tof_pkg::i2c_phase_t phase;
    logic start_cond, stop_cond, scl_rise, scl_fall;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_q} <= {i_scl, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {i_sda, sda_m, sda_s};
        end
    end

    assign start_cond = scl_s && scl_q && sda_q && !sda_s;
    assign stop_cond = scl_s && scl_q && !sda_q && sda_s;
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            phase <= tof_pkg::I2C_IDLE;
            in_ack <= 1'b0;
            host_ack <= 1'b0;
            bit_cnt <= 4'h0;
            shifter <= 8'h00;
            o_sda_drive <= 1'b0;
            o_wr_stb <= 1'b0;
            o_rd_stb <= 1'b0;
            o_addr <= 8'h00;
            o_wdata <= 8'h00;
        end else begin
            o_wr_stb <= 1'b0;
            o_rd_stb <= 1'b0;
            // pointer advances only after a data byte has been handed over
            if (o_wr_stb) begin
                o_addr <= o_addr + 8'h01;
            end
            if (!i_enable || stop_cond) begin
                phase <= tof_pkg::I2C_IDLE;
                in_ack <= 1'b0;
                o_sda_drive <= 1'b0;
            end else if (start_cond) begin
                phase <= tof_pkg::I2C_ADDR;
                in_ack <= 1'b0;
                bit_cnt <= 4'h0;
                o_sda_drive <= 1'b0;
            end else if (phase != tof_pkg::I2C_IDLE && scl_rise) begin
                if (in_ack) begin
                    // controller acknowledge decides whether the next byte is fetched
                    if (host_ack && sda_s) begin
                        phase <= tof_pkg::I2C_IDLE;
                    end else if (host_ack) begin
                        o_rd_stb <= 1'b1;
                    end
                end else if (phase != tof_pkg::I2C_RDATA) begin
                    shifter <= {shifter[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (phase != tof_pkg::I2C_IDLE && scl_fall) begin
                if (in_ack) begin
                    in_ack <= 1'b0;
                    host_ack <= 1'b0;
                    bit_cnt <= 4'h0;
                    if (phase == tof_pkg::I2C_RDATA) begin
                        shifter <= i_rdata;
                        o_sda_drive <= ~i_rdata[7];
                        o_addr <= o_addr + 8'h01;
                    end else begin
                        o_sda_drive <= 1'b0;
                    end
                end else if (phase == tof_pkg::I2C_RDATA) begin
                    if (bit_cnt == 4'h7) begin
                        o_sda_drive <= 1'b0;
                        in_ack <= 1'b1;
                        host_ack <= 1'b1;
                    end else begin
                        o_sda_drive <= ~shifter[6];
                        shifter <= {shifter[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end else if (bit_cnt == 4'h8) begin
                    in_ack <= 1'b1;
                    host_ack <= 1'b0;
                    o_sda_drive <= 1'b1;
                    unique case (phase)
                        tof_pkg::I2C_ADDR: begin
                            if (shifter[7:1] != DEV_ADDR) begin
                                phase <= tof_pkg::I2C_IDLE;
                                in_ack <= 1'b0;
                                o_sda_drive <= 1'b0;
                            end else if (shifter[0]) begin
                                phase <= tof_pkg::I2C_RDATA;
                                o_rd_stb <= 1'b1;
                            end else begin
                                phase <= tof_pkg::I2C_PTR;
                            end
                        end
                        tof_pkg::I2C_PTR: begin
                            o_addr <= shifter;
                            phase <= tof_pkg::I2C_WDATA;
                        end
                        tof_pkg::I2C_WDATA: begin
                            o_wdata <= shifter;
                            o_wr_stb <= 1'b1;
                        end
                        default: begin
                            phase <= tof_pkg::I2C_IDLE;
                        end
                    endcase
                end
            end
        end
    end
endmodule

/* File: testbench/host_i2c_model.sv */
// host i2c controller model paced by its own link clock
`timescale 1ns/100ps
`include "tof_defines.svh"
module host_i2c_model (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_rel
);
    logic lclk = 1'b0;
    logic nak = 1'b0;
    always #24 lclk = ~lclk;
    initial begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge lclk);
    endtask
    task automatic st();
        o_sda_rel = 1'b1;
        w(4);
        o_scl = 1'b1;
        w(8);
        o_sda_rel = 1'b0;
        w(8);
        o_scl = 1'b0;
    endtask
    // data moves only a quarter period after scl falls
    task automatic xb(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            w(4);
            o_sda_rel = tx[i];
            w(4);
            o_scl = 1'b1;
            w(8);
            rx[i] = i_sda;
            o_scl = 1'b0;
        end
    endtask
    task automatic go(input logic [7:0] a, input logic [7:0] d, input logic rd, output logic [7:0] q);
        logic [8:0] r;
        st();
        xb({`TOF_I2C_ADDR, 2'b01}, r);
        nak |= r[0];
        xb({a, 1'b1}, r);
        nak |= r[0];
        if (rd) begin
            st();
            xb({`TOF_I2C_ADDR, 2'b11}, r);
            nak |= r[0];
            xb(9'h1ff, r);
            q = r[8:1];
        end else begin
            xb({d, 1'b1}, r);
            nak |= r[0];
        end
        w(4);
        o_sda_rel = 1'b0;
        w(4);
        o_scl = 1'b1;
        w(8);
        o_sda_rel = 1'b1;
        w(8);
    endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench of the measurement sequencer
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, cen_n = 1'b0, ss = 1'b0;
    logic sda_o, sda_dn, irq_o, irq_d, bias, meas, done, pen, scl, sda_rel;
    logic [3:0] er;
    logic [7:0] ef, thr, q, v;
    int fail_count = 0, compares = 0, k, mdl[int];
    wire logic sda = sda_rel & (sda_dn | sda_o);
    wire logic irq_n = irq_d | irq_o;
    always #20 clk = ~clk;
    host_i2c_model host_i2c_model_inst (.i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel));
    tof_measurement_sequencer #(.TICK_CYCLES(4)) tof_measurement_sequencer_inst (.i_clk_sys(clk), .i_reset(rst),
        .i_chip_enable_low(cen_n), .i_sample_start(ss), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_o),
        .o_sda_drive_n(sda_dn), .o_irq_out(irq_o), .o_irq_drive_n(irq_d), .o_bias_on(bias), .o_measuring(meas),
        .o_sample_done(done), .o_emitter_pulse_en(pen), .o_emitter_range(er), .o_emitter_fine(ef),
        .o_threshold_current(thr));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_i2c_model_inst.go(a, d, 1'b0, q);
        if (a != 8'hb0) mdl[a] = d;
    endtask
    task automatic rd(input logic [7:0] a);
        host_i2c_model_inst.go(a, 8'h00, 1'b1, q);
        chk(q, 8'(mdl.exists(a) ? mdl[a] : 0));
    endtask
    task automatic wdone(input int n);
        k = 0;
        while (done !== 1'b1 && k < n) begin
            @(posedge clk);
            #1 k++;
        end
        chk(8'(k < n), 8'h01);
    endtask
    task automatic trig();
        @(posedge clk);
        #1 ss = 1'b1;
        repeat (8) @(posedge clk);
        #1 ss = 1'b0;
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #3000000 fail_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(88));
        v = 8'($urandom);
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(8'({irq_n, meas, bias}), 8'h05);
        rd(8'h01);
        rd(8'h13);
        wr(8'h90, v);
        wr(8'h91, ~v);
        wr(8'h93, v ^ 8'h5a);
        chk(8'(er), v & 8'h0f);
        chk(ef, ~v);
        chk(thr, 8'h00);
        wr(8'hb0, 8'h55);
        wr(8'h01, 8'h01);
        chk(8'(bias), 8'h00);
        wr(8'h01, 8'h00);
        @(posedge clk);
        #1 cen_n = 1'b1;
        repeat (6) @(posedge clk);
        #1 chk(8'(bias), 8'h00);
        cen_n = 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(8'(bias), 8'h01);
        rd(8'h91);
        wr(8'h13, 8'h01);
        wr(8'h14, 8'h01);
        wr(8'h10, 8'h03);
        trig();
        chk(8'({meas, pen}), 8'h03);
        chk(thr, v ^ 8'h5a);
        trig();
        wdone(150);
        @(posedge clk);
        #1 chk(8'({irq_n, meas}), 8'h00);
        mdl[8'h61] = 1;
        rd(8'h61);
        host_i2c_model_inst.go(8'h60, 8'h00, 1'b1, q);
        chk(q, 8'h01);
        chk(8'(irq_n), 8'h01);
        wr(8'hb0, 8'h49);
        wdone(150);
        mdl[8'h61] = 2;
        rd(8'h61);
        wr(8'h13, 8'h00);
        wr(8'h11, 8'h40);
        wr(8'hb0, 8'h49);
        wdone(300);
        @(posedge clk);
        #1 wdone(300);
        chk(8'(k > 250 && k < 262), 8'h01);
        wr(8'hb0, 8'hd1);
        chk(8'(meas), 8'h00);
        mdl[8'h61] = 0;
        rd(8'h61);
        wr(8'h02, 8'h00);
        wr(8'hb0, 8'hd7);
        mdl.delete();
        rd(8'h91);
        rd(8'h02);
        chk(ef, 8'h00);
        chk(8'(host_i2c_model_inst.nak), 8'h00);
        report_and_stop();
    end
endmodule
